// >>> rtl/ppape_pkg.sv
// Package with register map, field layout and reset values for the address pin enable block.
package ppape_pkg;

   // Register byte offsets on the bus.
   localparam logic [11:0] PPAPE_OFS_ENABLE   = 12'h000;
   localparam logic [11:0] PPAPE_OFS_PORT_OUT = 12'h004;
   localparam logic [11:0] PPAPE_OFS_PORT_DIR = 12'h008;
   localparam logic [11:0] PPAPE_OFS_PIN_IN   = 12'h00C;

   // Width of the pin group and the enable register.
   localparam int          PPAPE_NPINS        = 16;

   // Field positions inside the enable register.
   localparam int          PPAPE_BIT_CS2      = 15;
   localparam int          PPAPE_BIT_CS1      = 14;
   localparam int          PPAPE_ADDR_HI      = 13;
   localparam int          PPAPE_ADDR_LO      = 2;
   localparam int          PPAPE_STB_HI       = 1;
   localparam int          PPAPE_STB_LO       = 0;

   // Reset values.
   localparam logic [15:0] PPAPE_RST_ENABLE   = 16'h0000;
   localparam logic [15:0] PPAPE_RST_PORT     = 16'h0000;
   localparam logic [31:0] PPAPE_RD_ZERO      = 32'h0000_0000;

   // AHB transfer type code for a non-sequential transfer.
   localparam logic [1:0]  PPAPE_HTRANS_NSEQ  = 2'b10;

endpackage

// >>> rtl/ppape_pin_mux.sv
// Per-pin selection between the parallel port and general-purpose port I/O.
`timescale 1ns/1ps
module ppape_pin_mux
   import ppape_pkg::*;
#(
   parameter int NPINS = PPAPE_NPINS
) (
   input  wire logic [NPINS-1:0] sel,       // High hands the pin to the parallel port.
   input  wire logic [NPINS-1:0] par_out,   // Parallel port drive value.
   input  wire logic [NPINS-1:0] par_oe,    // Parallel port drive enable.
   input  wire logic [NPINS-1:0] gpio_out,  // Port I/O drive value.
   input  wire logic [NPINS-1:0] gpio_oe,   // Port I/O drive enable.
   output logic      [NPINS-1:0] pin_out,   // Selected drive value.
   output logic      [NPINS-1:0] pin_oe     // Selected drive enable.
);

   // One selector per pin; the same structure serves every group of enable bits.
   genvar i;
   generate
      for (i = 0; i < NPINS; i++) begin : g_pin
         assign pin_out[i] = sel[i] ? par_out[i] : gpio_out[i];
         assign pin_oe[i]  = sel[i] ? par_oe[i]  : gpio_oe[i];
      end
   endgenerate

endmodule // ppape_pin_mux

// >>> rtl/ppape_top.sv
// Address pin enable register with AHB-Lite slave and pin function selection.
//
// Notes on behaviour
// - Enable bit 15 gives pin 15 to the port as address 15 or chip select 2.
// - Enable bit 14 gives pin 14 to the port as address 14 or chip select 1.
// - Enable bits 13 to 2 give pins 13 to 2 to the port as address lines.
// - Enable bits 1 and 0 give pins 1 and 0 to address or latch strobes.
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ppape_top
   import ppape_pkg::*;
#(
   parameter int NPINS = PPAPE_NPINS
) (
   input  wire logic             hclk,       // Bus clock, 250 MHz.
   input  wire logic             hresetn,    // Asynchronous reset, active low.
   input  wire logic             hsel,       // Slave select.
   input  wire logic [31:0]      haddr,      // Byte address.
   input  wire logic [1:0]       htrans,     // Transfer type.
   input  wire logic             hwrite,     // Write when high.
   input  wire logic [2:0]       hsize,      // Transfer size.
   input  wire logic [31:0]      hwdata,     // Write data.
   input  wire logic             hready,     // Bus ready from the interconnect.
   output logic      [31:0]      hrdata,     // Read data.
   output logic                  hreadyout,  // Slave ready.
   output logic                  hresp,      // Always OKAY.
   input  wire logic [NPINS-1:0] par_out,    // Parallel port drive values.
   input  wire logic [NPINS-1:0] par_oe,     // Parallel port drive enables.
   input  wire logic [NPINS-1:0] pin_in,     // Pin levels from the pads.
   output logic      [NPINS-1:0] pin_out,    // Pad drive values.
   output logic      [NPINS-1:0] pin_oe,     // Pad drive enables, high while driving.
   output logic      [NPINS-1:0] par_sel     // Pin function: high for the parallel port.
);

   // Registered state; the enable word is held as its four pin groups.
   logic             cs2_pin_enable;
   logic             cs1_pin_enable;
   logic [11:0]      addr_line_pin_enables;
   logic [1:0]       latch_strobe_pin_enables;
   logic [NPINS-1:0] port_out;
   logic [NPINS-1:0] port_dir;
   logic [NPINS-1:0] pin_sync1;
   logic [NPINS-1:0] pin_sync2;
   logic             wr_pend;
   logic [11:0]      wr_addr;

   // Combinational nets.
   logic [NPINS-1:0] address_pin_enable;
   logic [NPINS-1:0] sel_vec;
   logic [NPINS-1:0] mux_out;
   logic [NPINS-1:0] mux_oe;
   logic             addr_phase;
   logic             rd_take;
   logic             wr_take;
   logic [11:0]      ofs;
   logic             wr_enable;
   logic             wr_out;
   logic             wr_dir;
   logic [NPINS-1:0] wdata;

   // Address phase decode; only whole-word transfers are expected, so the size is not read.
   assign addr_phase = hsel & hready & htrans[1];
   assign rd_take    = addr_phase & ~hwrite;
   assign wr_take    = addr_phase & hwrite;
   assign ofs        = haddr[11:0];
   assign wr_enable  = wr_pend & (wr_addr == PPAPE_OFS_ENABLE);
   assign wr_out     = wr_pend & (wr_addr == PPAPE_OFS_PORT_OUT);
   assign wr_dir     = wr_pend & (wr_addr == PPAPE_OFS_PORT_DIR);
   assign wdata      = hwdata[NPINS-1:0];

   // The enable word is rebuilt from its groups, each steering its own pins.
   assign sel_vec            = {cs2_pin_enable,
                                cs1_pin_enable,
                                addr_line_pin_enables,
                                latch_strobe_pin_enables};
   assign address_pin_enable = sel_vec;

   // Read data mux; unmapped offsets read as zero.
   function automatic logic [31:0] rd_mux(input logic [11:0] a, input logic [NPINS-1:0] en,
                                          input logic [NPINS-1:0] po, input logic [NPINS-1:0] pd,
                                          input logic [NPINS-1:0] pi);
      logic [31:0] r;
      r = PPAPE_RD_ZERO;
      case (a)
         PPAPE_OFS_ENABLE:   r[NPINS-1:0] = en;
         PPAPE_OFS_PORT_OUT: r[NPINS-1:0] = po;
         PPAPE_OFS_PORT_DIR: r[NPINS-1:0] = pd;
         PPAPE_OFS_PIN_IN:   r[NPINS-1:0] = pi;
         default:            r = PPAPE_RD_ZERO;
      endcase
      return r;
   endfunction

   // Write address is held into the data phase, where hwdata becomes valid.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
      end else begin
         wr_pend <= wr_take;
         wr_addr <= ofs;
      end
   end

   // Chip select 2 pin; a write takes effect at once, with no interlock against port traffic.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cs2_pin_enable <= PPAPE_RST_ENABLE[PPAPE_BIT_CS2];
      end else if (wr_enable) begin
         cs2_pin_enable <= wdata[PPAPE_BIT_CS2];
      end
   end

   // Chip select 1 pin; reset leaves it as port I/O.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cs1_pin_enable <= PPAPE_RST_ENABLE[PPAPE_BIT_CS1];
      end else if (wr_enable) begin
         cs1_pin_enable <= wdata[PPAPE_BIT_CS1];
      end
   end

   // Address line pins; the upper half of the bus word is dropped on purpose.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_line_pin_enables <= PPAPE_RST_ENABLE[PPAPE_ADDR_HI:PPAPE_ADDR_LO];
      end else if (wr_enable) begin
         addr_line_pin_enables <= wdata[PPAPE_ADDR_HI:PPAPE_ADDR_LO];
      end
   end

   // Latch strobe pins; reset leaves both as port I/O.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_strobe_pin_enables <= PPAPE_RST_ENABLE[PPAPE_STB_HI:PPAPE_STB_LO];
      end else if (wr_enable) begin
         latch_strobe_pin_enables <= wdata[PPAPE_STB_HI:PPAPE_STB_LO];
      end
   end

   // Port I/O output latch, used while a pin is not given to the port.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_out <= PPAPE_RST_PORT;
      end else if (wr_out) begin
         port_out <= wdata;
      end
   end

   // Port I/O direction; a pin stays undriven until software asks for it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_dir <= PPAPE_RST_PORT;
      end else if (wr_dir) begin
         port_dir <= wdata;
      end
   end

   // Pin levels come from outside the clock domain, so two stages precede any reader.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_sync1 <= PPAPE_RST_PORT;
         pin_sync2 <= PPAPE_RST_PORT;
      end else begin
         pin_sync1 <= pin_in;
         pin_sync2 <= pin_sync1;
      end
   end

   // Read data is registered in the address phase, so every access is zero wait.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= PPAPE_RD_ZERO;
      end else if (rd_take) begin
         hrdata <= rd_mux(ofs, address_pin_enable, port_out, port_dir, pin_sync2);
      end
   end

   // Per-pin selection; the mux itself is combinational and registered below.
   ppape_pin_mux #(
      .NPINS    (NPINS)
   ) u_mux (
      .sel      (sel_vec),
      .par_out  (par_out),
      .par_oe   (par_oe),
      .gpio_out (port_out),
      .gpio_oe  (port_dir),
      .pin_out  (mux_out),
      .pin_oe   (mux_oe)
   );

   // Pad drive comes from flip-flops; this adds one cycle of delay on the drive path.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= PPAPE_RST_PORT;
         pin_oe  <= PPAPE_RST_PORT;
      end else begin
         pin_out <= mux_out;
         pin_oe  <= mux_oe;
      end
   end

   // Function select follows the enable word one edge after it is written.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         par_sel <= PPAPE_RST_ENABLE;
      end else begin
         par_sel <= sel_vec;
      end
   end

   // Ready stays high, since no access here needs a wait state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
      end else begin
         hreadyout <= 1'b1;
      end
   end

   // The slave never reports an error, so the response stays OKAY.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

endmodule // ppape_top

// >>> bench/ppape_chk_asserts.sv
// Checker of the address pin enable block at the ports of its top module.
`timescale 1ns/1ps
module ppape_chk
   import ppape_pkg::*;
#(parameter int NPINS = PPAPE_NPINS) (
   input wire logic             hclk,     // Bus clock.
   input wire logic             hresetn,  // Reset, active low.
   input wire logic             hsel,     // Slave select.
   input wire logic [31:0]      haddr,    // Byte address.
   input wire logic [1:0]       htrans,   // Transfer type.
   input wire logic             hwrite,   // Write when high.
   input wire logic [31:0]      hwdata,   // Write data.
   input wire logic             hready,   // Bus ready.
   input wire logic [NPINS-1:0] par_oe,   // Port drive enables.
   input wire logic [NPINS-1:0] pin_oe,   // Pad drive enables.
   input wire logic [NPINS-1:0] par_sel   // Pin function.
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // A write is taken at the address edge; the select shows two edges after its data.
   wire wr_en = hsel && hready && htrans[1] && hwrite && haddr[11:0] == PPAPE_OFS_ENABLE;
   cs2_sel_a: assert property (wr_en |=> ##2 par_sel[15] == $past(hwdata[15], 2))
      else $error("chip select 2 pin function wrong");
   cs1_sel_a: assert property (wr_en |=> ##2 par_sel[14] == $past(hwdata[14], 2))
      else $error("chip select 1 pin function wrong");
   addr_sel_a: assert property (wr_en |=> ##2 par_sel[13:2] == $past(hwdata[13:2], 2))
      else $error("address line pin function wrong");
   strobe_sel_a: assert property (wr_en |=> ##2 par_sel[1:0] == $past(hwdata[1:0], 2))
      else $error("latch strobe pin function wrong");
   rst_io_a: assert property ($rose(hresetn) |-> par_sel == '0 && pin_oe == '0)
      else $error("pins not port I/O after reset");
   // Only a settled select is judged, since the mux may follow the register one edge early.
   port_drive_a: assert property ($stable(par_sel) |=>
      $changed(par_sel) || (((pin_oe ^ $past(par_oe)) & par_sel) == '0))
      else $error("selected pin not driven by the parallel port");
   cover property (wr_en);
   cover property (par_sel[PPAPE_BIT_CS2] && !par_sel[PPAPE_BIT_CS1]);
   cover property (par_sel[1:0] == 2'b11);
endmodule // ppape_chk

// >>> bench/ppape_tb.sv
// Self-checking bench for the address pin enable register and pin selection.
`timescale 1ns/1ps
module tb;
   import ppape_pkg::*;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, rnd = 32'h4e25_58cd;
   logic [1:0]  htrans = 0;
   logic [15:0] par_out = 0, par_oe = 0, pin_in = 0, pin_out, pin_oe, par_sel;
   logic [15:0] tbl [6] = '{16'h8000, 16'h4000, 16'h3ffc, 16'h0003, 16'hffff, 16'h0000};
   int          m_en, m_po, m_pd, num_errors = 0, samples_checked = 0;
   always #2 hclk = ~hclk;
   // The one slave's ready is the bus ready.
   ppape_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .par_out(par_out),
      .par_oe(par_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .par_sel(par_sel));
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Bounded wait for an edge that samples ready high.
   task automatic wait_rdy();
      int n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         test_done();
      end
   endtask
   task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge hclk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, PPAPE_HTRANS_NSEQ, w, 20'h0_0000, a};
      wait_rdy();
      {hsel, htrans, hwdata} <= {3'b000, d};
      wait_rdy();
      rd = hrdata;
   endtask
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      check("par_sel", par_sel, 0);
      xfer(0, PPAPE_OFS_ENABLE, 0);
      check("enable", rd, 0);
      // Fixed corner values first, then random ones with noise in the upper half.
      for (int i = 0; i < 24; i++) begin
         rnd = xs(rnd);
         m_en = i < 6 ? tbl[i] : rnd[15:0];
         m_po = rnd[31:16];
         m_pd = rnd[23:8];
         {par_out, par_oe} <= xs(rnd);
         xfer(1, PPAPE_OFS_ENABLE, {rnd[31:16], m_en[15:0]});
         xfer(1, PPAPE_OFS_PORT_OUT, m_po);
         xfer(1, PPAPE_OFS_PORT_DIR, m_pd);
         xfer(0, PPAPE_OFS_ENABLE, 0);
         check("enable", rd, m_en);
         check("cs2", par_sel[15], m_en[15]);
         check("cs1", par_sel[14], m_en[14]);
         check("addr", par_sel[13:2], m_en[13:2]);
         check("strobe", par_sel[1:0], m_en[1:0]);
         check("pin_oe", pin_oe, (m_en & par_oe) | (~m_en & m_pd));
         check("pin_out", pin_out, (m_en & par_out) | (~m_en & m_po));
      end
      // An unmapped write must leave the enable word alone.
      pin_in <= rnd[15:0];
      xfer(1, 12'h010, 32'hffff_ffff);
      xfer(0, 12'h010, 0);
      check("unmapped", rd, 0);
      xfer(0, PPAPE_OFS_ENABLE, 0);
      check("enable", rd, m_en);
      xfer(0, PPAPE_OFS_PIN_IN, 0);
      check("pin_in", rd, rnd[15:0]);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(0, PPAPE_OFS_ENABLE, 0);
      check("enable", rd, 0);
      check("pin_oe", pin_oe, 0);
      check("par_sel", par_sel, 0);
      check("slave state", {hreadyout, hresp}, 32'h0000_0002);
      test_done();
   end
endmodule // tb
bind ppape_top ppape_chk #(.NPINS(NPINS)) chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .par_oe(par_oe), .pin_oe(pin_oe), .par_sel(par_sel));
